// >>> verilog/sacc_pkg.sv
// ==========================================================================
// Shared constants of the converter cycle control
package sacc_pkg;

  // ========================================================================
  // Clock and timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int DEBOUNCE_NS = 50;
  localparam int CONV_TIME_NS = 2500;
  // Least times round up to whole clock cycles
  localparam int DEBOUNCE_CYC = (DEBOUNCE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CONV_CYC = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ========================================================================
  // Command field and word length codes
  localparam logic [3:0] CMD_POWER_DOWN = 4'he;
  localparam logic [3:0] CMD_RESERVED = 4'hf;
  localparam logic [3:0] CHAN_LAST_EXT = 4'ha;
  localparam logic [3:0] CHAN_TEST_MID = 4'hb;
  localparam logic [3:0] CHAN_TEST_LOW = 4'hc;
  localparam logic [1:0] LEN_8 = 2'h1;
  localparam logic [1:0] LEN_16 = 2'h3;
  localparam logic [1:0] LEN_RESET = 2'h0;
  localparam logic [4:0] CMD_FALL = 5'h04;
  localparam logic [3:0] LEN_RISE = 4'h6;
  localparam logic [3:0] CMD_RISES = 4'h8;

  // Internal test voltage codes
  localparam logic [11:0] TEST_MID_CODE = 12'h800;
  localparam logic [11:0] TEST_LOW_CODE = 12'h000;
  localparam logic [11:0] TEST_HIGH_CODE = 12'hfff;

  // ========================================================================
  // Register map (byte addresses) and reset values
  localparam logic [7:0] REG_ANALOG = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_COMMAND = 8'h08;
  localparam logic [11:0] ANALOG_RESET = 12'h000;
  localparam logic [11:0] RESULT_RESET = 12'h000;

  // ========================================================================
  // Sequencer states, Gray coded along idle -> transfer -> convert
  typedef enum logic [1:0] {
    SACC_IDLE = 2'b00,
    SACC_XFER = 2'b01,
    SACC_CONV = 2'b11
  } sacc_state_t;

endpackage

// >>> verilog/sacc_pin_sync.sv
`timescale 1ns/100ps
// ==========================================================================
// Two-flop synchroniser with edge detection on the settled level
module sacc_pin_sync
#(
  parameter logic RESET_LEVEL = 1'b0
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta;
  logic prev;

  // First flop feeds only the second one
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta <= RESET_LEVEL;
      level <= RESET_LEVEL;
      prev <= RESET_LEVEL;
    end
    else if (ce)
    begin
      meta <= pin;
      level <= meta;
      prev <= level;
    end
  end

  // Edges of the settled level
  assign rise = ce & level & ~prev;
  assign fall = ce & ~level & prev;

endmodule

// >>> verilog/sacc_top.sv
`timescale 1ns/100ps
// Functional notes
// - Select going high aborts any transfer or conversion in progress.
// - Select returning low in time keeps the earlier result buffered for next cycle.
// - With select held low, first result bit appears as conversion-done rises.
// - Conversion after the last falling edge drops done and forces output low.
// - Select toggled between conversions: first bit appears at select falling.
// - Each later shift-clock falling edge advances output until word length sent.
// - Command 1110b in first four clocks powers down at fourth falling edge.
// - Powered down: no conversion, output buffer keeps the last result.
// - Serial logic keeps shifting in power-down; host completes the cycle.
// - After power-on reset the device starts powered down.
// - Leave power-down on command other than 1110b/1111b, then convert once.
// - Automatic low power after conversion; wake once select is asserted.
// - Command field picks eleven inputs, three test voltages, or power-down.
// - Multiplexer breaks the old input before making the new one.
// - Sampling starts at fourth falling edge, held at the last one.
// - Test voltages pass the same sample and convert path as inputs.
// - Top four command bits address the conversion after this cycle.
// - Length code 00/10 gives 12 bits, 11 gives 16, 01 gives 8.
// - Select high floats the output at once, ignores clock after debounce.
// - Settled select falling edge resets the internal sequencing state.
module sacc_top
#(
  parameter int CONV_CYCLES = sacc_pkg::CONV_CYC,
  parameter int DEBOUNCE_CYCLES = sacc_pkg::DEBOUNCE_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cs_n,
  input wire logic io_clk,
  input wire logic data_in,
  output logic data_out,
  output logic data_out_oe,
  output logic eoc,
  output logic [3:0] mux_sel,
  output logic mux_connect,
  output logic sample_en,
  output logic powered_down,
  output logic auto_low_power,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  // ========================================================================
  // Pin synchronisers
  logic cs_lvl, cs_rise, cs_fall;
  logic sck_rise_raw, sck_fall_raw;
  logic din_lvl;

  sacc_pin_sync #(.RESET_LEVEL(1'b1)) u_cs (
    .clk(clk), .rst(rst), .ce(ce), .pin(cs_n),
    .level(cs_lvl), .rise(cs_rise), .fall(cs_fall)
  );
  sacc_pin_sync #(.RESET_LEVEL(1'b0)) u_sck (
    .clk(clk), .rst(rst), .ce(ce), .pin(io_clk),
    .level(), .rise(sck_rise_raw), .fall(sck_fall_raw)
  );
  sacc_pin_sync #(.RESET_LEVEL(1'b0)) u_din (
    .clk(clk), .rst(rst), .ce(ce), .pin(data_in),
    .level(din_lvl), .rise(), .fall()
  );

  // ========================================================================
  // Select debounce
  logic [15:0] deb_cnt;
  logic deb_done;
  logic cs_settle;
  logic sck_ok;
  logic sck_rise, sck_fall;

  assign deb_done = (deb_cnt >= 16'(DEBOUNCE_CYCLES));
  assign cs_settle = ce & ~cs_lvl & (deb_cnt == 16'(DEBOUNCE_CYCLES - 1));
  // Clock passes while select high is not yet settled, or low has settled
  assign sck_ok = cs_lvl ? ~deb_done : deb_done;
  assign sck_rise = sck_rise_raw & sck_ok;
  assign sck_fall = sck_fall_raw & sck_ok;

  // Counter restarts on every select change, saturates when settled
  always_ff @(posedge clk)
  begin
    if (rst)
      deb_cnt <= 16'h0000;
    else if (ce)
      deb_cnt <= (cs_rise | cs_fall) ? 16'h0000 : (deb_done ? deb_cnt : deb_cnt + 16'h0001);
  end

  // ========================================================================
  // Register file state
  logic [11:0] analog_val;
  logic [11:0] result_buf;
  logic [7:0] last_cmd;

  // ========================================================================
  // Sequencer state
  sacc_pkg::sacc_state_t state;
  logic [4:0] fall_cnt;
  logic [3:0] rise_cnt;
  logic [7:0] cmd_sr;
  logic [1:0] cur_len;
  logic [1:0] conv_len;
  logic conv_lsb;
  logic conv_bip;
  logic [15:0] out_sr;
  logic [15:0] conv_cnt;
  logic [3:0] conv_chan;
  logic [3:0] pend_chan;
  logic mux_pend;

  // Command decode and word length
  logic [7:0] next_sr;
  logic [3:0] cmd_now;
  logic cmd_pd;
  logic cmd_rsv;
  logic [4:0] len_bits;
  logic [4:0] next_fall;
  logic last_fall;
  logic conv_done;

  assign next_sr = {cmd_sr[6:0], din_lvl};
  // Command sits low after four rises, high once all eight are in
  assign cmd_now = (rise_cnt == sacc_pkg::CMD_RISES) ? cmd_sr[7:4] : cmd_sr[3:0];
  assign cmd_pd = (cmd_now == sacc_pkg::CMD_POWER_DOWN);
  assign cmd_rsv = (cmd_now == sacc_pkg::CMD_RESERVED);
  // Codes 00 and 10 both mean twelve bits
  assign len_bits = (cur_len == sacc_pkg::LEN_8) ? 5'd8 :
                    (cur_len == sacc_pkg::LEN_16) ? 5'd16 : 5'd12;
  assign next_fall = fall_cnt + 5'd1;
  assign last_fall = sck_fall & (state == sacc_pkg::SACC_XFER) & (next_fall == len_bits);
  assign conv_done = (state == sacc_pkg::SACC_CONV) & (conv_cnt == 16'(CONV_CYCLES - 1));

  // ========================================================================
  // Result formatting: sending order, first bit at the top
  logic [11:0] chan_code;
  logic [11:0] signed_code;
  logic [11:0] fmt_src;
  logic [15:0] right_word;
  logic [15:0] rev_word;
  logic [15:0] send_word;

  // Test voltages enter the same result path as the inputs
  assign chan_code = (conv_chan <= sacc_pkg::CHAN_LAST_EXT) ? analog_val :
                     (conv_chan == sacc_pkg::CHAN_TEST_MID) ? sacc_pkg::TEST_MID_CODE :
                     (conv_chan == sacc_pkg::CHAN_TEST_LOW) ? sacc_pkg::TEST_LOW_CODE :
                     sacc_pkg::TEST_HIGH_CODE;
  // Bipolar differs from unipolar only in the inverted sign bit
  assign signed_code = {chan_code[11] ^ conv_bip, chan_code[10:0]};
  // The fresh code bypasses the buffer on the edge that latches it
  assign fmt_src = (conv_done & ~cs_lvl) ? signed_code : result_buf;
  assign right_word = (conv_len == sacc_pkg::LEN_8) ? {8'h00, fmt_src[11:4]} :
                      (conv_len == sacc_pkg::LEN_16) ? {fmt_src, 4'h0} :
                      {4'h0, fmt_src};
  assign rev_word = {<<{right_word}};
  assign send_word = conv_lsb ? rev_word :
                     (conv_len == sacc_pkg::LEN_8) ? {right_word[7:0], 8'h00} :
                     (conv_len == sacc_pkg::LEN_16) ? right_word :
                     {right_word[11:0], 4'h0};

  // ========================================================================
  // Result buffer, latched at the end of a conversion only
  always_ff @(posedge clk)
  begin
    if (rst)
      result_buf <= sacc_pkg::RESULT_RESET;
    else if (ce & conv_done & ~cs_lvl)
      result_buf <= signed_code;
  end

  // Output shifter: cycle start reloads, falling edges advance
  logic load_word;
  assign load_word = cs_fall | cs_settle | (ce & conv_done & ~cs_lvl) | last_fall;

  always_ff @(posedge clk)
  begin
    if (rst)
      out_sr <= 16'h0000;
    else if (ce)
    begin
      if (load_word)
        out_sr <= send_word;
      else if (sck_fall & (state == sacc_pkg::SACC_XFER))
        out_sr <= {out_sr[14:0], 1'b0};
    end
  end

  // ========================================================================
  // Serial output pin and its enable
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      data_out <= 1'b0;
      data_out_oe <= 1'b0;
    end
    else if (ce)
    begin
      if (cs_rise)
        data_out_oe <= 1'b0;
      else if (cs_fall)
        data_out_oe <= 1'b1;
      if (cs_fall | cs_settle)
        data_out <= send_word[15];
      else if (conv_done & ~cs_lvl)
        data_out <= send_word[15];
      else if (state == sacc_pkg::SACC_CONV)
        data_out <= 1'b0;
      else if (last_fall)
        data_out <= 1'b0;
      else if (sck_fall & (state == sacc_pkg::SACC_XFER))
        data_out <= out_sr[14];
      else if (state == sacc_pkg::SACC_XFER & fall_cnt == 5'd0 & rise_cnt == 4'h0)
        data_out <= out_sr[15];
    end
  end

  // ========================================================================
  // Sequencer, counters and command capture
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= sacc_pkg::SACC_IDLE;
      fall_cnt <= 5'd0;
      rise_cnt <= 4'h0;
      cmd_sr <= 8'h00;
      cur_len <= sacc_pkg::LEN_RESET;
      conv_cnt <= 16'h0000;
      eoc <= 1'b1;
    end
    else if (ce)
    begin
      if (cs_rise)
      begin
        state <= sacc_pkg::SACC_IDLE;
        eoc <= 1'b1;
      end
      else if (cs_settle)
      begin
        state <= sacc_pkg::SACC_XFER;
        fall_cnt <= 5'd0;
        rise_cnt <= 4'h0;
        conv_cnt <= 16'h0000;
        eoc <= 1'b1;
      end
      else if (state == sacc_pkg::SACC_CONV)
      begin
        conv_cnt <= conv_cnt + 16'h0001;
        if (conv_done)
        begin
          state <= sacc_pkg::SACC_XFER;
          eoc <= 1'b1;
        end
      end
      else if (state == sacc_pkg::SACC_XFER)
      begin
        // Command bits shift in on rising edges; only the first eight count
        if (sck_rise & (rise_cnt != sacc_pkg::CMD_RISES))
        begin
          cmd_sr <= next_sr;
          rise_cnt <= rise_cnt + 4'h1;
          if (rise_cnt == sacc_pkg::LEN_RISE - 4'h1)
            cur_len <= next_sr[1:0];
        end
        if (last_fall)
        begin
          fall_cnt <= 5'd0;
          rise_cnt <= 4'h0;
          conv_cnt <= 16'h0000;
          // A normal command leaves power-down and converts; others stay in transfer
          if (~cmd_pd & ~cmd_rsv)
          begin
            state <= sacc_pkg::SACC_CONV;
            eoc <= 1'b0;
          end
        end
        else if (sck_fall)
          fall_cnt <= next_fall;
      end
    end
  end

  // ========================================================================
  // Power state, conversion settings and multiplexer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      powered_down <= 1'b1;
      auto_low_power <= 1'b0;
      conv_chan <= 4'h0;
      conv_len <= sacc_pkg::LEN_RESET;
      conv_lsb <= 1'b0;
      conv_bip <= 1'b0;
      last_cmd <= 8'h00;
      pend_chan <= 4'h0;
      mux_pend <= 1'b0;
      mux_sel <= 4'h0;
      mux_connect <= 1'b0;
      sample_en <= 1'b0;
    end
    else if (ce)
    begin
      mux_pend <= 1'b0;
      if (mux_pend)
      begin
        mux_sel <= pend_chan;
        mux_connect <= 1'b1;
        sample_en <= 1'b1;
      end
      // Sleep right after a result, wake once select settles low
      if (conv_done)
        auto_low_power <= 1'b1;
      else if (cs_settle)
        auto_low_power <= 1'b0;
      if (cs_rise)
        sample_en <= 1'b0;
      else if (sck_fall & (state == sacc_pkg::SACC_XFER) & (next_fall == sacc_pkg::CMD_FALL))
      begin
        if (cmd_pd)
          powered_down <= 1'b1;
        else if (~cmd_rsv)
        begin
          // Open the old input first, connect the new one a cycle later
          mux_connect <= 1'b0;
          pend_chan <= cmd_now;
          mux_pend <= 1'b1;
        end
      end
      if (last_fall)
      begin
        sample_en <= 1'b0;
        last_cmd <= cmd_sr;
        if (~cmd_pd & ~cmd_rsv)
        begin
          powered_down <= 1'b0;
          conv_chan <= cmd_now;
          conv_len <= cmd_sr[3:2];
          conv_lsb <= cmd_sr[1];
          conv_bip <= cmd_sr[0];
        end
      end
    end
  end

  // ========================================================================
  // AHB-Lite slave: zero wait states, always OKAY
  logic addr_valid;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [31:0] status_word;
  logic [31:0] read_word;

  assign addr_valid = hsel & hready & htrans[1];
  assign status_word = {12'h000, state, auto_low_power, powered_down, conv_chan, result_buf};
  // Unmapped addresses read zero and ignore writes
  assign read_word = (haddr[7:0] == sacc_pkg::REG_ANALOG) ? {20'h00000, analog_val} :
                     (haddr[7:0] == sacc_pkg::REG_STATUS) ? status_word :
                     (haddr[7:0] == sacc_pkg::REG_COMMAND) ? {24'h000000, last_cmd} :
                     32'h00000000;

  // Address phase captured; write data lands in the data phase
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      analog_val <= sacc_pkg::ANALOG_RESET;
    end
    else if (ce)
    begin
      wr_pend <= addr_valid & hwrite & (hsize == 3'h2);
      wr_addr <= haddr[7:0];
      if (addr_valid & ~hwrite)
        hrdata <= read_word;
      if (wr_pend & (wr_addr == sacc_pkg::REG_ANALOG))
        analog_val <= hwdata[11:0];
    end
  end

endmodule

// >>> testbench/sacc_top_asserts.sv
`timescale 1ns/100ps
// ==========================================
// Port checks of the converter cycle control
module sacc_top_asserts
#(
  parameter int CONV_CYCLES = 20
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic data_out,
  input wire logic data_out_oe,
  input wire logic eoc,
  input wire logic [3:0] mux_sel,
  input wire logic mux_connect,
  input wire logic sample_en,
  input wire logic powered_down,
  input wire logic auto_low_power
);
  int low_cnt;

  // Length of each low stretch of done
  always_ff @(posedge clk)
  begin
    if (rst || eoc)
      low_cnt <= 0;
    else
      low_cnt <= low_cnt + 1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================
  // Assertions
  AST_RESET_STATE: assert property ($fell(rst) |-> powered_down && eoc && !data_out_oe)
    else $error("reset state wrong");
  AST_CS_FLOAT: assert property (cs_n [*5] |-> !data_out_oe)
    else $error("output driven while deselected");
  AST_ABORT: assert property ($rose(cs_n) |-> ##[1:16] eoc)
    else $error("conversion not aborted");
  AST_OUT_LOW: assert property (!eoc |-> !data_out)
    else $error("output not low in conversion");
  AST_CONV_LEN: assert property ($rose(eoc) && !cs_n |->
    low_cnt >= CONV_CYCLES - 1 && low_cnt <= CONV_CYCLES + 2)
    else $error("conversion length wrong");
  AST_FIRST_BIT: assert property ($rose(eoc) && !cs_n |-> data_out_oe)
    else $error("first bit not driven at done");
  AST_AUTO_LP: assert property ($rose(eoc) && !cs_n |-> ##[0:25] auto_low_power)
    else $error("no automatic low power");
  AST_PD_NO_CONV: assert property ($fell(eoc) |-> !powered_down)
    else $error("conversion while powered down");
  AST_BBM: assert property (!$stable(mux_sel) |-> !$past(mux_connect))
    else $error("mux switched while connected");
  AST_SAMPLE: assert property (sample_en |-> mux_connect)
    else $error("sampling with mux open");
  AST_HOLD: assert property ($fell(eoc) |-> !sample_en)
    else $error("sample not held at conversion");

  // Main scenarios reached
  cover property ($fell(eoc));
  cover property ($rose(powered_down));
  cover property ($rose(eoc) && !cs_n);
endmodule

bind sacc_top sacc_top_asserts #(.CONV_CYCLES(CONV_CYCLES)) chk_u (.clk(clk), .rst(rst),
  .cs_n(cs_n), .data_out(data_out), .data_out_oe(data_out_oe), .eoc(eoc),
  .mux_sel(mux_sel), .mux_connect(mux_connect), .sample_en(sample_en),
  .powered_down(powered_down), .auto_low_power(auto_low_power));

// >>> testbench/sacc_host.sv
`timescale 1ns/100ps
// ==========================================
// Host serial port: select, shift clock, command
module sacc_host
(
  input wire logic clk,
  input wire logic data_out,
  input wire logic data_out_oe,
  output logic cs_n,
  output logic io_clk,
  output logic data_in
);
  logic line;

  // Floating output line has no pull: show the inverse of the last level
  assign line = data_out_oe ? data_out : ~data_out;

  // Idle: deselected, clock low
  initial
  begin
    cs_n = 1'b1;
    io_clk = 1'b0;
    data_in = 1'b0;
  end

  // One whole cycle of n clocks, 125 ns period, MSB of command first
  task automatic xfer(input logic [7:0] cmd, input int n, input bit toggle,
    output logic [15:0] got);
    got = 16'h0000;
    if (toggle)
    begin
      cs_n <= 1'b1;
      repeat (15) @(posedge clk);
    end
    cs_n <= 1'b0;
    repeat (25) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      data_in <= (i < 8) ? cmd[7 - i] : ~data_in;
      repeat (12) @(posedge clk);
      io_clk <= 1'b1;
      repeat (13) @(posedge clk);
      got = {got[14:0], line};
      io_clk <= 1'b0;
    end
    data_in <= ~data_in;
  endtask

  // Deselect in mid-operation
  task release_cs;
    cs_n <= 1'b1;
  endtask
endmodule

// >>> testbench/sacc_top_bench.sv
`timescale 1ns/100ps
// ==========================================
// Self-checking bench of the cycle control
module sacc_top_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic cs_n, io_clk, data_in, data_out, data_out_oe, eoc, mux_connect;
  logic sample_en, powered_down, auto_low_power, hreadyout, hresp;
  logic [3:0] mux_sel;
  logic [31:0] hrdata, rd;
  logic [15:0] got;
  int fails = 0;
  int num_checks = 0;

  // 200 MHz
  always #2.5 clk = ~clk;

  sacc_top #(.CONV_CYCLES(20), .DEBOUNCE_CYCLES(3)) dut_u (.clk(clk), .rst(rst), .ce(ce),
    .cs_n(cs_n), .io_clk(io_clk), .data_in(data_in), .data_out(data_out),
    .data_out_oe(data_out_oe), .eoc(eoc), .mux_sel(mux_sel), .mux_connect(mux_connect),
    .sample_en(sample_en), .powered_down(powered_down), .auto_low_power(auto_low_power),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp));

  sacc_host host_u (.clk(clk), .data_out(data_out), .data_out_oe(data_out_oe),
    .cs_n(cs_n), .io_clk(io_clk), .data_in(data_in));

  // ==========================================
  // Reporting
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask

  // ==========================================
  // Bus and wait helpers
  task edge_rdy;
    int k;
    @(posedge clk);
    for (k = 0; hreadyout !== 1'b1; k++)
    begin
      if (k == 50)
      begin
        fails++;
        end_of_test();
      end
      @(posedge clk);
    end
  endtask

  // Single word transfer: hold address until ready, then data phase
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= 3'h2;
    edge_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy();
    rd = hrdata;
  endtask

  // Bounded wait for a done level; a slow done counts as a mismatch
  task wait_eoc(input logic lvl);
    int k;
    for (k = 0; eoc !== lvl; k++)
    begin
      if (k == 2000)
      begin
        fails++;
        end_of_test();
      end
      @(posedge clk);
    end
  endtask

  task conv;
    wait_eoc(1'b0);
    wait_eoc(1'b1);
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(powered_down, 1);
    chk({hreadyout, hresp}, 32'h2);
    bus(1'b0, sacc_pkg::REG_STATUS, 32'h0);
    chk(rd[16], 1);
    bus(1'b1, sacc_pkg::REG_ANALOG, 32'h5a3);
    bus(1'b0, sacc_pkg::REG_ANALOG, 32'h0);
    chk(rd, 32'h5a3);
    bus(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    host_u.xfer(8'h30, 12, 1'b1, got);
    wait_eoc(1'b0);
    chk(powered_down, 0);
    chk(mux_sel, 3);
    wait_eoc(1'b1);
    // Select held low: result appears at done
    host_u.xfer(8'hd0, 12, 1'b0, got);
    chk(got[11:0], 12'h5a3);
    conv();
    repeat (4) @(posedge clk);
    chk(auto_low_power, 1);
    host_u.xfer(8'he0, 12, 1'b1, got);
    chk(got[11:0], sacc_pkg::TEST_HIGH_CODE);
    repeat (40) @(posedge clk);
    chk(powered_down, 1);
    chk(eoc, 1);
    bus(1'b0, sacc_pkg::REG_STATUS, 32'h0);
    chk(rd[11:0], sacc_pkg::TEST_HIGH_CODE);
    host_u.xfer(8'hbc, 16, 1'b1, got);
    chk(got[15:4], sacc_pkg::TEST_HIGH_CODE);
    conv();
    host_u.xfer(8'h34, 8, 1'b1, got);
    chk(got[7:0], {sacc_pkg::TEST_MID_CODE, 4'h0} >> 8);
    conv();
    // Reserved command: no conversion follows
    host_u.xfer(8'hf4, 8, 1'b1, got);
    chk(got[7:0], 8'h5a);
    repeat (40) @(posedge clk);
    chk(eoc, 1);
    // Abort a running conversion, then read the kept buffer
    host_u.xfer(8'h3c, 16, 1'b1, got);
    wait_eoc(1'b0);
    host_u.release_cs();
    repeat (8) @(posedge clk);
    chk(data_out_oe, 0);
    chk(eoc, 1);
    host_u.xfer(8'h34, 8, 1'b1, got);
    chk(got[7:0], 8'h5a);
    conv();
    end_of_test();
  end
endmodule
